/* File: design/wpug_pkg.sv */
// constants, types and register map of the write-protect and user-mode guard
package wpug_pkg;
  localparam int PHYS_W = 20;
  localparam int REG_AW = 16;
  localparam int PERIPH_W = 3;
  localparam int NUM_EVT = 3;
  // register offsets
  localparam logic [15:0] OFS_DUAL = 16'h0420;
  localparam logic [15:0] OFS_WPMODE = 16'h0440;
  localparam logic [15:0] OFS_MASKLO = 16'h0460;
  localparam logic [15:0] OFS_MASKHI = 16'h0461;
  localparam logic [15:0] OFS_SEGA = 16'h0480;
  localparam logic [15:0] OFS_SEGB = 16'h0484;
  localparam logic [15:0] OFS_USEREN = 16'h04e0;
  localparam logic [15:0] OFS_STAT = 16'h04f8;
  localparam logic [15:0] OFS_IMASK = 16'h04f9;
  localparam logic [15:0] OFS_STATE = 16'h04fa;
  // segment register layout: +0 block select, +1 low subs, +2 high subs
  localparam logic [1:0] SEG_SEL = 2'h0;
  localparam logic [1:0] SEG_LO = 2'h1;
  localparam logic [1:0] SEG_HI = 2'h2;
  // field positions
  localparam int BIT_WPALL = 0;
  localparam int BIT_DUAL = 0;
  localparam int BIT_USEREN = 0;
  localparam int EVT_WP = 0;
  localparam int EVT_SYS = 1;
  localparam int EVT_STK = 2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_SEGSEL = 4'h0;
  // interrupt vectors
  localparam logic [7:0] VEC_WP = 8'h90;
  localparam logic [7:0] VEC_SYS = 8'h80;
  localparam logic [7:0] VEC_STK = 8'hb0;
  localparam logic VSEL_WP = 1'b0;
  localparam logic VSEL_SYS = 1'b1;
  localparam logic VSEL_STK = 1'b1;
  // interrupt levels
  localparam logic [1:0] WP_IRQ_LEVEL = 2'h3;
  localparam logic [1:0] USER_PRI_MAX = 2'h1;

  typedef struct packed {
    logic valid;
    logic [PHYS_W-1:0] addr;
    logic [7:0] data;
  } wpug_wr_t;

  typedef struct packed {
    logic valid;
    logic [PERIPH_W-1:0] periph;
  } wpug_io_t;

  typedef struct packed {
    logic valid;
    logic [PERIPH_W-1:0] periph;
    logic [1:0] pri;
  } wpug_irq_t;
endpackage : wpug_pkg

/* File: design/wpug_guard.sv */
// write protection and system/user privilege guard
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module wpug_guard #(
  parameter int NUM_PERIPH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [wpug_pkg::REG_AW-1:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  input wire logic [7:0] vecBase,
  input wire wpug_pkg::wpug_wr_t cpuWr,
  output wpug_pkg::wpug_wr_t memWr,
  input wire logic enterUser,
  input wire logic intEntry,
  input wire logic privInstr,
  input wire logic stackViol,
  input wire wpug_pkg::wpug_io_t ioReq,
  output logic ioGrant,
  input wire wpug_pkg::wpug_irq_t irqIn,
  output wpug_pkg::wpug_irq_t irqOut,
  output logic userMode,
  output logic violIrq,
  output logic [1:0] violPri,
  output logic [15:0] violVector
);
  import wpug_pkg::*;

  // refuse peripheral counts that the index field cannot serve
  if (NUM_PERIPH < 1 || NUM_PERIPH > (1 << PERIPH_W)) begin : gBadPeriph
    $error("NUM_PERIPH out of range");
  end

  logic dualEn_r;
  logic wpAll_r;
  logic [15:0] blkMask_r;
  logic [3:0] segSel_r [2];
  logic [15:0] segMask_r [2];
  logic [NUM_PERIPH-1:0] userEn_r;
  logic [NUM_EVT-1:0] stat_r;
  logic [NUM_EVT-1:0] stat_nxt;
  logic [NUM_EVT-1:0] imask_r;
  logic [NUM_EVT-1:0] imask_nxt;
  logic userMode_r;
  logic [7:0] rd_nxt;
  logic effUser;
  logic regWr;
  logic [3:0] blk;
  logic [3:0] sub;
  logic wpHit;
  logic wpApply;
  logic wrBlocked;
  logic ioOk;
  logic ioDeny;
  logic sysEvt;
  logic [NUM_EVT-1:0] pend;
  logic irqUserEn;
  logic [6:0] vecHi;

  // privilege only counts once dual mode is on
  assign effUser = userMode_r & dualEn_r;
  // user code cannot touch the guard registers
  assign regWr = regWrStb & ~effUser;

  // block and sub-block hit on the physical address
  assign blk = cpuWr.addr[19:16];
  assign sub = cpuWr.addr[15:12];
  assign wpHit = blkMask_r[blk]
    | ((blk == segSel_r[0]) & segMask_r[0][sub])
    | ((blk == segSel_r[1]) & segMask_r[1][sub]);
  assign wpApply = wpAll_r | effUser;
  assign wrBlocked = cpuWr.valid & wpHit & wpApply;

  // peripheral access gate
  assign ioOk = ~effUser | ((ioReq.periph < NUM_PERIPH) & userEn_r[ioReq.periph]);
  assign ioDeny = ioReq.valid & ~ioOk;
  assign sysEvt = ioDeny | (effUser & (regWrStb | privInstr));
  assign irqUserEn = (irqIn.periph < NUM_PERIPH) & userEn_r[irqIn.periph];

  // vector base bits shared by every violation vector
  assign vecHi = vecBase[7:1];

  // dual mode and protection mode control
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dualEn_r <= 1'b0;
      wpAll_r <= 1'b0;
    end else if (regWr) begin
      if (regAddr == OFS_DUAL) begin
        dualEn_r <= regWrData[BIT_DUAL];
      end
      if (regAddr == OFS_WPMODE) begin
        wpAll_r <= regWrData[BIT_WPALL];
      end
    end
  end

  // block masks and sub-block segments
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      blkMask_r <= {RST_BYTE, RST_BYTE};
      segSel_r[0] <= RST_SEGSEL;
      segSel_r[1] <= RST_SEGSEL;
      segMask_r[0] <= {RST_BYTE, RST_BYTE};
      segMask_r[1] <= {RST_BYTE, RST_BYTE};
    end else if (regWr) begin
      if (regAddr == OFS_MASKLO) begin
        blkMask_r[7:0] <= regWrData;
      end
      if (regAddr == OFS_MASKHI) begin
        blkMask_r[15:8] <= regWrData;
      end
      for (int s = 0; s < 2; s++) begin
        if (regAddr[15:2] == ((s == 0) ? OFS_SEGA[15:2] : OFS_SEGB[15:2])) begin
          case (regAddr[1:0])
            SEG_SEL: segSel_r[s] <= regWrData[3:0];
            SEG_LO: segMask_r[s][7:0] <= regWrData;
            SEG_HI: segMask_r[s][15:8] <= regWrData;
            default: ;
          endcase
        end
      end
    end
  end

  // one user-enable register per peripheral
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : gUserEn
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          userEn_r[gi] <= 1'b0;
        end else if (regWr && regAddr == OFS_USEREN + 16'(gi)) begin
          userEn_r[gi] <= regWrData[BIT_USEREN];
        end
      end
    end
  endgenerate

  // privilege state
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      userMode_r <= 1'b0;
    end else if (intEntry || !dualEn_r) begin
      userMode_r <= 1'b0;
    end else if (enterUser) begin
      userMode_r <= 1'b1;
    end
  end

  // sticky events, set beats write-one-clear
  always_comb begin
    stat_nxt = stat_r;
    if (regWr && regAddr == OFS_STAT) begin
      stat_nxt = stat_r & ~regWrData[NUM_EVT-1:0];
    end
    stat_nxt[EVT_WP] = stat_nxt[EVT_WP] | wrBlocked;
    stat_nxt[EVT_SYS] = stat_nxt[EVT_SYS] | sysEvt;
    stat_nxt[EVT_STK] = stat_nxt[EVT_STK] | stackViol;
  end

  // mask next value, so the irq level follows a mask write at once
  always_comb begin
    imask_nxt = imask_r;
    if (regWr && regAddr == OFS_IMASK) begin
      imask_nxt = regWrData[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stat_r <= '0;
      imask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      imask_r <= imask_nxt;
    end
  end

  // interrupt output and vector of the highest pending event
  assign pend = stat_r & imask_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      violIrq <= 1'b0;
      violPri <= 2'h0;
      violVector <= 16'h0000;
    end else begin
      violIrq <= |(stat_nxt & imask_nxt);
      violPri <= pend[EVT_WP] ? WP_IRQ_LEVEL : 2'h0;
      if (pend[EVT_WP]) begin
        violVector <= {vecBase[7:1], VSEL_WP, VEC_WP};
      end else if (pend[EVT_SYS]) begin
        violVector <= {vecBase[7:1], VSEL_SYS, VEC_SYS};
      end else if (pend[EVT_STK]) begin
        violVector <= {vecBase[7:1], VSEL_STK, VEC_STK};
      end
    end
  end

  // memory write pass-through with suppression
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      memWr <= '0;
    end else begin
      memWr.valid <= cpuWr.valid & ~wrBlocked;
      memWr.addr <= cpuWr.addr;
      memWr.data <= cpuWr.data;
    end
  end

  // peripheral grant and interrupt level clamp
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ioGrant <= 1'b0;
      irqOut <= '0;
      userMode <= 1'b0;
    end else begin
      ioGrant <= ioReq.valid & ioOk;
      irqOut.valid <= irqIn.valid;
      irqOut.periph <= irqIn.periph;
      irqOut.pri <= (irqUserEn && irqIn.pri > USER_PRI_MAX) ? USER_PRI_MAX : irqIn.pri;
      userMode <= userMode_r & dualEn_r;
    end
  end

  // register read, data in the next cycle
  always_comb begin
    rd_nxt = 8'h00;
    case (regAddr)
      OFS_STAT: rd_nxt = {5'h00, stat_r};
      OFS_IMASK: rd_nxt = {5'h00, imask_r};
      OFS_STATE: rd_nxt = {6'h00, wpAll_r, effUser};
      default: rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= regRdStb ? rd_nxt : 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence sBlkWr;
    cpuWr.valid && blkMask_r[cpuWr.addr[19:16]] && wpAll_r;
  endsequence
  sequence sSubWr;
    cpuWr.valid && wpAll_r && cpuWr.addr[19:16] == segSel_r[0]
      && segMask_r[0][cpuWr.addr[15:12]];
  endsequence
  sequence sDropped;
    !memWr.valid ##0 stat_r[EVT_WP];
  endsequence
  sequence sModeLow;
    !userMode_r ##1 !userMode;
  endsequence

  AST_BLOCK_WR: assert property (sBlkWr |=> sDropped)
    else $error("write to protected block passed");
  AST_SUB_WR: assert property (sSubWr |=> sDropped)
    else $error("write to protected sub-block passed");
  AST_USER_ONLY: assert property (cpuWr.valid && !wpAll_r && !effUser
      |=> memWr.valid && memWr.addr == $past(cpuWr.addr))
    else $error("system write blocked in user-only mode");
  AST_USER_WP: assert property (cpuWr.valid && effUser && wpHit |=> sDropped)
    else $error("user write to protected memory passed");
  AST_WP_VEC: assert property (pend[EVT_WP]
      |=> violVector == {$past(vecHi), VSEL_WP, VEC_WP} && violPri == WP_IRQ_LEVEL)
    else $error("wrong write-protect vector");
  AST_SYS_VEC: assert property (pend == (3'h1 << EVT_SYS)
      |=> violVector == {$past(vecHi), VSEL_SYS, VEC_SYS})
    else $error("wrong system-mode vector");
  AST_STK_VEC: assert property (pend == (3'h1 << EVT_STK)
      |=> violVector == {$past(vecHi), VSEL_STK, VEC_STK})
    else $error("wrong stack vector");
  AST_STK_EVT: assert property (stackViol |=> stat_r[EVT_STK])
    else $error("stack violation not recorded");
  AST_INT_SYS: assert property (intEntry |=> sModeLow)
    else $error("interrupt entry left user mode");
  AST_NO_DUAL: assert property (!dualEn_r |=> !userMode_r)
    else $error("user mode without dual enable");
  AST_IO_GRANT: assert property (ioReq.valid && !effUser |=> ioGrant)
    else $error("system access to peripheral refused");
  AST_IO_DENY: assert property (ioReq.valid && effUser && !ioOk
      |=> !ioGrant && stat_r[EVT_SYS])
    else $error("user access to reserved peripheral");
  AST_USER_REG: assert property (effUser && regWrStb |=> $stable(wpAll_r)
      && $stable(blkMask_r) && stat_r[EVT_SYS])
    else $error("user code changed guard registers");
  AST_PRIV_USER: assert property (effUser && privInstr |=> stat_r[EVT_SYS])
    else $error("privileged op in user mode not flagged");
  AST_IRQ_PRI: assert property (irqIn.valid && irqUserEn
      |=> irqOut.valid && irqOut.pri <= USER_PRI_MAX)
    else $error("user peripheral irq above lowest levels");
  AST_IRQ_OUT: assert property ((stat_r & imask_r) != 3'h0 |-> violIrq)
    else $error("pending unmasked event without interrupt");
endmodule : wpug_guard

/* File: test/wpug_core_model.sv */
// processor core and memory model on the far side of the guard
`timescale 1ns/1ps
module wpug_core_model (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reqValid,
  input wire logic [19:0] reqAddr,
  input wire logic [7:0] reqData,
  output wpug_pkg::wpug_wr_t cpuWr,
  input wire wpug_pkg::wpug_wr_t memWr,
  input wire logic [7:0] probePage,
  output logic [7:0] probeData
);
  import wpug_pkg::*;
  logic [7:0] mem [256];
  // one-cycle write request; idle bus shows inverted junk, not the last value
  always_ff @(posedge ref_clk) begin
    cpuWr.valid <= reqValid & ~sys_rst;
    cpuWr.addr <= reqValid ? reqAddr : ~cpuWr.addr;
    cpuWr.data <= reqValid ? reqData : ~cpuWr.data;
  end
  // memory keeps one byte per 4 KB page; only strobed writes land
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 256; i++) mem[i] <= 8'h00;
    end else if (memWr.valid) begin
      mem[memWr.addr[19:12]] <= memWr.data;
    end
  end
  assign probeData = mem[probePage];
endmodule : wpug_core_model

/* File: test/testbench.sv */
// register-level tests of the write-protect and user-mode guard
`timescale 1ns/1ps
module testbench;
  import wpug_pkg::*;
  logic ref_clk, sys_rst, regWrStb, regRdStb, enterUser, intEntry, privInstr, stackViol;
  logic reqValid, ioGrant, userMode, violIrq;
  logic [15:0] regAddr, violVector;
  logic [7:0] regWrData, regRdData, vecBase, reqData, probePage, probeData;
  logic [19:0] reqAddr;
  logic [1:0] violPri;
  wpug_wr_t cpuWr, memWr;
  wpug_io_t ioReq;
  wpug_irq_t irqIn, irqOut;
  int fails, n_checks, cycles;
  wpug_guard i_wpug_guard (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .vecBase(vecBase), .cpuWr(cpuWr), .memWr(memWr), .enterUser(enterUser),
    .intEntry(intEntry), .privInstr(privInstr), .stackViol(stackViol), .ioReq(ioReq),
    .ioGrant(ioGrant), .irqIn(irqIn), .irqOut(irqOut), .userMode(userMode),
    .violIrq(violIrq), .violPri(violPri), .violVector(violVector));
  wpug_core_model i_wpug_core_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqData(reqData), .cpuWr(cpuWr),
    .memWr(memWr), .probePage(probePage), .probeData(probeData));
  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input string name, input logic [19:0] got, input logic [19:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge ref_clk);
    regWrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
    @(posedge ref_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge ref_clk);
    regRdStb <= 1'b0;
    #1 chk(name, regRdData, exp);
  endtask : rd
  // core write, then look at the page it aimed at
  task automatic cw(input logic [19:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqData <= d;
    probePage <= a[19:12];
    @(posedge ref_clk);
    reqValid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk("memory", probeData, exp);
  endtask : cw
  // k: 0 enter user, 1 interrupt entry, 2 stack violation, 3 privileged op
  task automatic ev(input int k);
    @(posedge ref_clk);
    {enterUser, intEntry, stackViol, privInstr} <= 4'h8 >> k;
    @(posedge ref_clk);
    {enterUser, intEntry, stackViol, privInstr} <= 4'h0;
  endtask : ev
  task automatic io(input logic [2:0] p, input logic exp);
    @(posedge ref_clk);
    ioReq <= '{1'b1, p};
    @(posedge ref_clk);
    ioReq <= '0;
    #1 chk("ioGrant", ioGrant, exp);
  endtask : io
  task automatic irq(input logic [2:0] p, input logic [1:0] pri, input logic [1:0] exp);
    @(posedge ref_clk);
    irqIn <= '{1'b1, p, pri};
    @(posedge ref_clk);
    irqIn <= '0;
    #1 chk("irqPri", irqOut.pri, exp);
    chk("irqValid", irqOut.valid, 1'b1);
  endtask : irq
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  initial begin
    {sys_rst, regWrStb, regRdStb, enterUser, intEntry, privInstr, stackViol} = 7'h40;
    {regAddr, regWrData, reqValid, reqAddr, reqData, probePage} = '0;
    {ioReq, irqIn} = '0;
    vecBase = 8'h5b;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(OFS_STATE, 8'h00, "state");
    rd(OFS_STAT, 8'h00, "status");
    rd(16'h0100, 8'h00, "unmapped");
    $display("test reset done");
    // protection map: block 1, block 15, sub-block 2 of block 3
    wr(OFS_IMASK, 8'h07);
    wr(OFS_MASKLO, 8'h02);
    wr(OFS_MASKHI, 8'h80);
    wr(OFS_SEGA, 8'h03);
    wr(OFS_SEGA + 16'h1, 8'h04);
    cw(20'h10000, 8'h11, 8'h11);
    wr(OFS_WPMODE, 8'h01);
    rd(OFS_STATE, 8'h02, "state");
    cw(20'h10000, 8'h22, 8'h11);
    chk("violIrq", violIrq, 1'b1);
    chk("violPri", violPri, 2'h3);
    chk("violVector", violVector, 16'h5a90);
    cw(20'hf0000, 8'h33, 8'h00);
    cw(20'he0000, 8'h44, 8'h44);
    cw(20'h32000, 8'h55, 8'h00);
    cw(20'h31000, 8'h66, 8'h66);
    wr(OFS_SEGB, 8'h0c);
    wr(OFS_SEGB + 16'h2, 8'h80);
    cw(20'hcf000, 8'h99, 8'h00);
    cw(20'hce000, 8'haa, 8'haa);
    rd(OFS_STAT, 8'h01, "status");
    wr(OFS_STAT, 8'h01);
    rd(OFS_STAT, 8'h00, "status");
    chk("violIrq", violIrq, 1'b0);
    $display("test blocks done");
    // privilege modes
    wr(OFS_WPMODE, 8'h00);
    wr(OFS_USEREN + 16'h2, 8'h01);
    ev(0);
    rd(OFS_STATE, 8'h00, "state");
    wr(OFS_DUAL, 8'h01);
    ev(0);
    rd(OFS_STATE, 8'h01, "state");
    chk("userMode", userMode, 1'b1);
    cw(20'h10000, 8'h77, 8'h11);
    cw(20'h40000, 8'h88, 8'h88);
    io(3'h2, 1'b1);
    io(3'h3, 1'b0);
    irq(3'h2, 2'h3, 2'h1);
    irq(3'h5, 2'h3, 2'h3);
    wr(OFS_IMASK, 8'h00);
    rd(OFS_IMASK, 8'h07, "mask");
    rd(OFS_STAT, 8'h03, "status");
    ev(1);
    rd(OFS_STATE, 8'h00, "state");
    chk("userMode", userMode, 1'b0);
    wr(OFS_STAT, 8'h01);
    rd(OFS_STAT, 8'h02, "status");
    chk("violVector", violVector, 16'h5b80);
    chk("violPri", violPri, 2'h0);
    wr(OFS_STAT, 8'h02);
    ev(2);
    rd(OFS_STAT, 8'h04, "status");
    chk("violVector", violVector, 16'h5bb0);
    io(3'h3, 1'b1);
    wr(OFS_STAT, 8'h04);
    ev(3);
    rd(OFS_STAT, 8'h00, "status");
    ev(0);
    ev(3);
    ev(1);
    rd(OFS_STAT, 8'h02, "status");
    $display("test modes done");
    conclude();
  end
endmodule : testbench
